/* File: rtl/wdrs_pkg.sv */
package wdrs_pkg;

  // ********************************************************
  // bus layout
  // ********************************************************
  localparam int unsigned ADR_W = 8;
  localparam int unsigned DAT_W = 32;
  localparam logic [5:0] CTRL_IDX = 6'h21;
  localparam logic [5:0] CAUSE_IDX = 6'h22;

  // ********************************************************
  // watchdog_control_status fields
  // ********************************************************
  localparam int unsigned IRQF_BIT = 7;
  localparam int unsigned IE_BIT = 6;
  localparam int unsigned SEL3_BIT = 5;
  localparam int unsigned CU_BIT = 4;
  localparam int unsigned EN_BIT = 3;
  localparam int unsigned SEL_LO_MSB = 2;

  // ********************************************************
  // reset_cause_status fields
  // ********************************************************
  localparam int unsigned WD_RESET_CAUSE_FLAG_BIT = 3;
  localparam int unsigned BROWNOUT_CAUSE_FLAG_BIT = 2;
  localparam int unsigned EXTF_BIT = 1;
  localparam int unsigned POWERON_CAUSE_FLAG_BIT = 0;
  localparam logic [3:0] CAUSE_RST = 4'h1;

  // ********************************************************
  // timing
  // ********************************************************
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  localparam logic [3:0] SEL_MAX = 4'h9;
  localparam int unsigned BASE_OSC_CYCLES = 2048;
  localparam int unsigned CNT_BITS = 20;

  typedef enum logic [1:0] {
    MODE_STOP = 2'b00,
    MODE_IRQ = 2'b01,
    MODE_RST = 2'b10
  } wdrs_mode_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [ADR_W-1:0] adr;
    logic [DAT_W-1:0] dat;
  } wdrs_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [DAT_W-1:0] dat;
  } wdrs_wb_rsp_t;

endpackage

/* File: rtl/wdrs_top.sv */
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
// Overview of operation
// R1: cause register upper four bits read zero
// R2: watchdog cause flag set by watchdog reset
// R3: brownout cause flag set by brownout reset
// R4: pin cause flag set by external reset
// R5: poweron flag set by poweron, software clears
// R6: software reads then clears causes early
// R7: timeout in interrupt mode sets irq flag
// R8: interrupt requested only with both enables
// R9: enable and irq enable select timeout action
// R10: both set: timeout clears irq enable
// R11: change unlock clears after four cycles
// R12: disable only inside unlock window
// R13: prescaler changes only inside unlock window
// R14: level two never disables watchdog
// R15: level one: watchdog flag forces enable
// R16: init software clears flag and enable
// R17: four bit prescaler, bit five msb
// R18: codes zero to nine double from 2K
// R19: reserved codes fall back to valid code
// R20: counter advances on oscillator ticks
// R21: counter restarts on restart, disable, reset
// R22: reset mode timeout gives one cycle pulse
// R23: level two enable reads one
// R24: safety level strap sampled after reset
module wdrs_top #(
  parameter int unsigned BASE_CYCLES = wdrs_pkg::BASE_OSC_CYCLES,
  parameter int unsigned CNT_W = wdrs_pkg::CNT_BITS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire wdrs_pkg::wdrs_wb_req_t wb_req,
  output wdrs_pkg::wdrs_wb_rsp_t wb_rsp,
  input wire logic osc_tick,
  input wire logic wdr_restart,
  input wire logic gie,
  input wire logic irq_taken,
  input wire logic bor_event,
  input wire logic ext_event,
  input wire logic safety_level2_strap,
  output logic irq_req,
  output logic wd_reset_pulse
);
  import wdrs_pkg::*;

  // ********************************************************
  // state
  // ********************************************************
  logic irqf;
  logic ie;
  logic en;
  logic [3:0] sel;
  logic [2:0] cu_cnt;
  logic [3:0] flags;
  logic level2;
  logic strap_done;
  logic [CNT_W-1:0] cnt;

  // ********************************************************
  // bus decode
  // ********************************************************
  wire req_on = wb_req.cyc & wb_req.stb;
  wire ctrl_hit = (wb_req.adr[ADR_W-1:2] == CTRL_IDX);
  wire cause_hit = (wb_req.adr[ADR_W-1:2] == CAUSE_IDX);
  wire wr_take = req_on & wb_req.we & wb_req.sel[0] & wb_rsp.ack;
  wire wr_ctrl = wr_take & ctrl_hit;
  wire wr_cause = wr_take & cause_hit;
  wire [7:0] wd = wb_req.dat[7:0];
  wire wr_open = wr_ctrl & wd[CU_BIT] & wd[EN_BIT];
  wire cu = (cu_cnt != 3'h0);

  // ********************************************************
  // mode and timeout
  // ********************************************************
  wire en_eff = en | level2 | flags[WD_RESET_CAUSE_FLAG_BIT]; // [R14] [R15] [R23]
  wire soft_rst = wd_reset_pulse | bor_event | ext_event;
  wdrs_mode_t mode;
  assign mode = ie ? MODE_IRQ : (en_eff ? MODE_RST : MODE_STOP); // [R9]
  wire running = (mode != MODE_STOP);
  wire [3:0] sel_eff = (sel > SEL_MAX) ? SEL_MAX : sel; // [R17] [R19]
  wire [31:0] limit_full = 32'(BASE_CYCLES) << sel_eff; // [R18]
  wire [CNT_W-1:0] limit_m1 = CNT_W'(limit_full - 32'h0000_0001);
  wire timeout = running & osc_tick & (cnt == limit_m1); // [R20]
  wire to_irq = timeout & (mode == MODE_IRQ);
  wire to_rst = timeout & (mode == MODE_RST);

  wire [CNT_W-1:0] next_cnt =
    (soft_rst | wdr_restart | ~running | timeout) ? '0 : // [R21]
    (osc_tick ? CNT_W'(cnt + 1'b1) : cnt);

  // ********************************************************
  // control register next values
  // ********************************************************
  wire next_irqf = to_irq |
    (irqf & ~(wr_ctrl & wd[IRQF_BIT]) & ~irq_taken); // [R7]
  wire next_ie = (timeout & ie & en_eff) ? 1'b0 : // [R10]
    (wr_ctrl ? wd[IE_BIT] : ie);
  wire dis_ok = cu & ~level2 & ~flags[WD_RESET_CAUSE_FLAG_BIT];
  // a set watchdog cause flag latches enable, so clearing the flag alone
  // leaves the watchdog running until the timed disable
  wire next_en = flags[WD_RESET_CAUSE_FLAG_BIT] | (wr_ctrl ?
    (wd[EN_BIT] | (en & ~dis_ok)) : en); // [R12] [R14] [R15]
  wire [3:0] next_sel = (wr_ctrl & cu) ?
    {wd[SEL3_BIT], wd[SEL_LO_MSB:0]} : sel; // [R13]
  wire [2:0] next_cu_cnt = wr_open ? UNLOCK_CYCLES :
    ((wr_ctrl & ~wd[CU_BIT]) ? 3'h0 :
    (cu ? 3'(cu_cnt - 3'h1) : 3'h0)); // [R11]

  // ********************************************************
  // read mux
  // ********************************************************
  wire [7:0] ctrl_rd = {irqf, ie, sel[3], cu, en_eff, sel[2:0]};
  wire [7:0] cause_rd = {4'h0, flags}; // [R1]
  wire [DAT_W-1:0] rd_data = ctrl_hit ? {24'h00_0000, ctrl_rd} :
    (cause_hit ? {24'h00_0000, cause_rd} : '0);

  // ********************************************************
  // reset cause flags
  // ********************************************************
  wire [3:0] flag_set = {to_rst, bor_event, ext_event, 1'b0};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_flag
      wire clr = wr_cause & ~wd[gi];
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          flags[gi] <= CAUSE_RST[gi]; // [R5]
        end else begin
          flags[gi] <= flag_set[gi] | (flags[gi] & ~clr); // [R2] [R3] [R4]
        end
      end
    end
  endgenerate

  // ********************************************************
  // safety level strap
  // ********************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done <= 1'b0;
      level2 <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      level2 <= safety_level2_strap; // [R24]
    end
  end

  // ********************************************************
  // control register and counter
  // ********************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqf <= 1'b0;
      ie <= 1'b0;
      en <= 1'b0;
      sel <= 4'h0;
      cu_cnt <= 3'h0;
    end else if (soft_rst) begin
      irqf <= 1'b0;
      ie <= 1'b0;
      en <= 1'b0;
      sel <= 4'h0;
      cu_cnt <= 3'h0;
    end else begin
      irqf <= next_irqf;
      ie <= next_ie;
      en <= next_en;
      sel <= next_sel;
      cu_cnt <= next_cu_cnt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req <= 1'b0;
      wd_reset_pulse <= 1'b0;
    end else begin
      irq_req <= irqf & ie & gie; // [R8]
      wd_reset_pulse <= to_rst; // [R22]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_rsp <= '0;
    end else begin
      wb_rsp.ack <= req_on & ~wb_rsp.ack;
      wb_rsp.dat <= (req_on & ~wb_rsp.ack) ? rd_data : '0;
    end
  end

  // ********************************************************
  // assertions
  // ********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_rsv_zero;
    req_on && !wb_rsp.ack && cause_hit |=>
      wb_rsp.ack && wb_rsp.dat[7:4] == 4'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) // [R1]
    else $error("cause reserved bits not zero");

  property p_wd_reset_cause_flag_set;
    to_rst |=> flags[WD_RESET_CAUSE_FLAG_BIT] && wd_reset_pulse;
  endproperty
  a_wd_reset_cause_flag_set: assert property (p_wd_reset_cause_flag_set) // [R2]
    else $error("watchdog reset did not set cause flag");

  property p_bor_set;
    bor_event |=> flags[BROWNOUT_CAUSE_FLAG_BIT] && !en;
  endproperty
  a_bor_set: assert property (p_bor_set) // [R3]
    else $error("brownout flag not set");

  property p_ext_set;
    ext_event |=> flags[EXTF_BIT];
  endproperty
  a_ext_set: assert property (p_ext_set) // [R4]
    else $error("pin reset flag not set");

  property p_por_hold;
    flags[POWERON_CAUSE_FLAG_BIT] && !(wr_cause && !wd[POWERON_CAUSE_FLAG_BIT]) |=> flags[POWERON_CAUSE_FLAG_BIT];
  endproperty
  a_por_hold: assert property (p_por_hold) // [R5]
    else $error("poweron flag lost without write");

  property p_irqf_set;
    to_irq && !soft_rst |=> irqf;
  endproperty
  a_irqf_set: assert property (p_irqf_set) // [R7]
    else $error("timeout did not set irq flag");

  property p_irq_req;
    irq_req |-> $past(irqf) && $past(ie) && $past(gie);
  endproperty
  a_irq_req: assert property (p_irq_req) // [R8]
    else $error("irq request without both enables");

  property p_ie_clear;
    timeout && ie && en_eff && !soft_rst |=> !ie && irqf;
  endproperty
  a_ie_clear: assert property (p_ie_clear) // [R10]
    else $error("irq enable not cleared at timeout");

  property p_unlock_age;
    wr_open && !soft_rst ##1 (!wr_ctrl && !soft_rst)[*4] |=> !cu;
  endproperty
  a_unlock_age: assert property (p_unlock_age) // [R11]
    else $error("change unlock not closed after four cycles");

  property p_locked_en;
    en_eff && !cu && !soft_rst |=> en_eff;
  endproperty
  a_locked_en: assert property (p_locked_en) // [R12]
    else $error("watchdog disabled outside unlock window");

  property p_locked_sel;
    !cu && !soft_rst |=> $stable(sel);
  endproperty
  a_locked_sel: assert property (p_locked_sel) // [R13]
    else $error("prescaler changed outside unlock window");

  property p_level2;
    level2 |-> en_eff && ctrl_rd[EN_BIT];
  endproperty
  a_level2: assert property (p_level2) // [R14]
    else $error("level two watchdog not enabled");

  property p_wd_reset_cause_flag_force;
    flags[WD_RESET_CAUSE_FLAG_BIT] |-> en_eff && mode != MODE_STOP;
  endproperty
  a_wd_reset_cause_flag_force: assert property (p_wd_reset_cause_flag_force) // [R15]
    else $error("cause flag did not force enable");

  property p_pulse_one;
    wd_reset_pulse |=> !wd_reset_pulse;
  endproperty
  a_pulse_one: assert property (p_pulse_one) // [R22]
    else $error("reset pulse longer than one cycle");

  property p_restart;
    wdr_restart |=> cnt == '0;
  endproperty
  a_restart: assert property (p_restart) // [R21]
    else $error("counter not restarted");

  property p_mode_stop;
    !ie && !en_eff |=> cnt == '0;
  endproperty
  a_mode_stop: assert property (p_mode_stop) // [R9]
    else $error("stopped watchdog counter not held at zero");

  property p_irq_not_rst;
    timeout && ie && !soft_rst |=> irqf && !wd_reset_pulse;
  endproperty
  a_irq_not_rst: assert property (p_irq_not_rst) // [R9]
    else $error("interrupt mode timeout did not give interrupt");

  property p_no_tick;
    !osc_tick |=> cnt == '0 || $stable(cnt);
  endproperty
  a_no_tick: assert property (p_no_tick) // [R20]
    else $error("counter moved without oscillator tick");

  property p_tick_step;
    osc_tick && running && !timeout && !soft_rst && !wdr_restart |=>
      cnt == CNT_W'($past(cnt) + 1'b1);
  endproperty
  a_tick_step: assert property (p_tick_step) // [R20]
    else $error("counter did not advance on oscillator tick");

  property p_limit;
    sel <= SEL_MAX |-> limit_full == (32'(BASE_CYCLES) << sel);
  endproperty
  a_limit: assert property (p_limit) // [R18]
    else $error("timeout length does not double per code");

  property p_sel_fallback;
    sel > SEL_MAX |-> limit_full == (32'(BASE_CYCLES) << SEL_MAX);
  endproperty
  a_sel_fallback: assert property (p_sel_fallback) // [R19]
    else $error("reserved prescaler code not mapped to valid code");

  property p_rd_sel;
    req_on && !wb_rsp.ack && ctrl_hit |=>
      wb_rsp.dat[5] == $past(sel[3]) && wb_rsp.dat[2:0] == $past(sel[2:0]);
  endproperty
  a_rd_sel: assert property (p_rd_sel) // [R17]
    else $error("prescaler bits misplaced in control read");

  property p_strap;
    strap_done |=> $stable(level2);
  endproperty
  a_strap: assert property (p_strap) // [R24]
    else $error("safety level changed after sampling");

  property p_lvl2_sel;
    level2 && wr_ctrl && !cu && !soft_rst |=> $stable(sel);
  endproperty
  a_lvl2_sel: assert property (p_lvl2_sel) // [R13]
    else $error("level two prescaler changed without unlock");

  c_reset_to: cover property (to_rst);
  c_irq_to: cover property (to_irq ##1 irq_req);
  c_disable: cover property (wr_open ##[1:6] (wr_ctrl && !next_en && en));
  c_sel_chg: cover property (wr_ctrl && cu && next_sel != sel);

endmodule

/* File: tb/test_watchdog_reset_status.sv */
`timescale 1ns/1ps
module test_watchdog_reset_status;
  import wdrs_pkg::*;
  // ************************************************
  // clock, stimulus and counters
  // ************************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  wdrs_wb_req_t req = '0;
  wdrs_wb_rsp_t rsp;
  logic tick = 1'b0, rstrt = 1'b0, gie = 1'b0, taken = 1'b0;
  logic bor = 1'b0, ext = 1'b0, lvl2 = 1'b0;
  logic irq, wdp;
  logic [31:0] q;
  int n_errors = 0, checks_done = 0, n_pulse = 0;
  localparam logic [7:0] CA = {CTRL_IDX, 2'b00};
  localparam logic [7:0] RA = {CAUSE_IDX, 2'b00};

  initial begin
    forever #20 clk = ~clk;
  end

  wdrs_top #(.BASE_CYCLES(4), .CNT_W(12)) dut (
    .clk(clk), .rst_n(rst_n), .wb_req(req), .wb_rsp(rsp),
    .osc_tick(tick), .wdr_restart(rstrt), .gie(gie),
    .irq_taken(taken), .bor_event(bor), .ext_event(ext),
    .safety_level2_strap(lvl2), .irq_req(irq), .wd_reset_pulse(wdp)
  );

  always @(posedge clk) begin
    if (wdp === 1'b1)
      n_pulse <= n_pulse + 1;
  end

  // ************************************************
  // shared tasks
  // ************************************************
  task automatic finish_test;
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b1, we, 4'h1, a, {24'h00_0000, d}};
    do @(posedge clk); while (rsp.ack !== 1'b1);
    q = rsp.dat;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 8'h00);
  endtask

  task automatic do_reset(input logic l2);
    @(posedge clk);
    rst_n <= 1'b0;
    lvl2 <= l2;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  // one pulse: 0 brownout, 1 pin, 2 restart, 3 vector taken
  task automatic side(input int k);
    @(posedge clk);
    {taken, rstrt, ext, bor} <= 4'h1 << k;
    @(posedge clk);
    {taken, rstrt, ext, bor} <= 4'h0;
    repeat (2) @(posedge clk);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
    repeat (3) @(posedge clk);
  endtask

  // nothing after n-1 ticks, the event right after tick n
  task automatic expect_to(input int n, input bit as_irq);
    int p0;
    p0 = n_pulse;
    ticks(n - 1);
    chk(as_irq ? {31'h0, irq} : 32'(n_pulse - p0), 32'h0);
    ticks(1);
    chk(as_irq ? {31'h0, irq} : 32'(n_pulse - p0), 32'h1);
  endtask

  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_por;
    rd(RA);
    chk(q, 32'h0000_0001);
    rd(CA);
    chk(q, 32'h0000_0000);
    wb(1'b1, RA, 8'hFF);
    rd(RA);
    chk(q, 32'h0000_0001);
    rd(8'h90);
    chk(q, 32'h0000_0000);
  endtask

  task automatic t_causes;
    side(0);
    rd(RA);
    chk(q, 32'h0000_0005);
    side(1);
    rd(RA);
    chk(q, 32'h0000_0007);
    wb(1'b1, RA, 8'h01);
    rd(RA);
    chk(q, 32'h0000_0001);
    wb(1'b1, RA, 8'h00);
    rd(RA);
    chk(q, 32'h0000_0000);
  endtask

  task automatic t_unlock;
    wb(1'b1, CA, 8'h08);
    wb(1'b1, CA, 8'h00);
    rd(CA);
    chk(q, 32'h0000_0008);
    wb(1'b1, CA, 8'h18);
    repeat (6) @(posedge clk);
    rd(CA);
    chk(q, 32'h0000_0008);
    wb(1'b1, CA, 8'h00);
    rd(CA);
    chk(q, 32'h0000_0008);
    wb(1'b1, CA, 8'h18);
    wb(1'b1, CA, 8'h00);
    rd(CA);
    chk(q, 32'h0000_0000);
  endtask

  task automatic t_sel;
    wb(1'b1, CA, 8'h08);
    wb(1'b1, CA, 8'h0B);
    rd(CA);
    chk(q, 32'h0000_0008);
    wb(1'b1, CA, 8'h18);
    wb(1'b1, CA, 8'h0B);
    rd(CA);
    chk(q, 32'h0000_000B);
    side(2);
    ticks(31);
    side(2);
    expect_to(32, 1'b0);
    rd(RA);
    chk(q, 32'h0000_0008);
    rd(CA);
    chk(q, 32'h0000_0008);
    wb(1'b1, CA, 8'h18);
    wb(1'b1, CA, 8'h00);
    rd(CA);
    chk(q, 32'h0000_0008);
    wb(1'b1, RA, 8'h00);
    wb(1'b1, CA, 8'h18);
    wb(1'b1, CA, 8'h00);
    rd(CA);
    chk(q, 32'h0000_0000);
    wb(1'b1, CA, 8'h08);
    wb(1'b1, CA, 8'h18);
    wb(1'b1, CA, 8'h2F);
    expect_to(2048, 1'b0);
    wb(1'b1, RA, 8'h00);
    wb(1'b1, CA, 8'h18);
    wb(1'b1, CA, 8'h00);
    rd(CA);
    chk(q, 32'h0000_0000);
  endtask

  task automatic t_irq;
    int p;
    @(posedge clk);
    gie <= 1'b1;
    wb(1'b1, CA, 8'h40);
    expect_to(4, 1'b1);
    rd(CA);
    chk(q, 32'h0000_00C0);
    @(posedge clk);
    gie <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, CA, 8'hC0);
    rd(CA);
    chk(q, 32'h0000_0040);
    gie <= 1'b1;
    ticks(4);
    chk({31'h0, irq}, 32'h1);
    side(3);
    chk({31'h0, irq}, 32'h0);
    p = n_pulse;
    wb(1'b1, CA, 8'h48);
    side(2);
    ticks(4);
    rd(CA);
    chk(q, 32'h0000_0088);
    chk(32'(n_pulse - p), 32'h0);
    wb(1'b1, CA, 8'h88);
    side(2);
    expect_to(4, 1'b0);
    wb(1'b1, RA, 8'h00);
    wb(1'b1, CA, 8'h18);
    wb(1'b1, CA, 8'h00);
    p = n_pulse;
    ticks(8);
    chk(32'(n_pulse - p), 32'h0);
  endtask

  task automatic t_lvl2;
    do_reset(1'b1);
    rd(CA);
    chk(q, 32'h0000_0008);
    wb(1'b1, CA, 8'h18);
    wb(1'b1, CA, 8'h00);
    rd(CA);
    chk(q, 32'h0000_0008);
    wb(1'b1, CA, 8'h01);
    rd(CA);
    chk(q, 32'h0000_0008);
    wb(1'b1, CA, 8'h18);
    wb(1'b1, CA, 8'h01);
    rd(CA);
    chk(q, 32'h0000_0009);
  endtask

  initial begin
    do_reset(1'b0);
    t_por;
    t_causes;
    t_unlock;
    t_sel;
    t_irq;
    t_lvl2;
    finish_test;
  end

  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    finish_test;
  end
endmodule
